// File: logic/lsw_top.sv
// Lock status, heartbeat, code error and window timing of the modem.
// Assumes rx symbols arrive recovered and synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module lsw_top
    import lsw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] rate_select,
    input  wire logic [1:0] handshake_bw_select,
    input  wire logic       txd,
    input  wire logic       rts,
    input  wire logic       dtr,
    input  wire logic       rx_sym_valid,
    input  wire logic [3:0] rx_sym,
    input  wire logic       rx_sym_last,
    input  wire logic       rx_burst_start,
    input  wire logic       rx_data_bit,
    input  wire logic [1:0] rx_hs,
    output logic            carrier_lock_n,
    output logic            code_error_flag,
    output logic            heartbeat_out,
    output logic            rxd,
    output logic            cts,
    output logic            dsr,
    output logic            tx_window,
    output logic            rx_window,
    output logic            tx_optical,
    output logic [3:0]      tx_sym,
    output logic            tx_sym_valid
);
    typedef enum logic [1:0] {LSW_IDLE, LSW_TX, LSW_RX} lsw_win_t;

    typedef struct packed {
        lsw_win_t    win_reg;
        logic [23:0] frame_cnt_reg;
        logic [24:0] hb_cnt_reg;
        logic        locked_reg;
        logic [1:0]  miss_reg;
        logic        got_burst_reg;
        logic        err_reg;
        logic        hb_reg;
        logic        rxd_reg;
        logic        cts_reg;
        logic        dsr_reg;
        logic [1:0]  hs_last_reg;
        logic [15:0] hs_gap_reg;
        logic        hs_pend_reg;
        logic        tx_opt_reg;
        logic [3:0]  tx_sym_reg;
        logic        tx_val_reg;
        logic        rd_wait_reg;
        logic [4:0]  ctrl_cnt_reg;
    } lsw_st_t;

    lsw_st_t s_reg;
    lsw_st_t s_next;

    logic             viol;
    logic             fifo_wr;
    logic [REC_W-1:0] fifo_wd;
    logic             fifo_rd;
    logic [REC_W-1:0] fifo_rdata;
    logic             fifo_empty;
    logic             fifo_full;
    logic [23:0]      frame_len;
    logic [15:0]      hs_gap;

    lsw_code_check u_check (
        .clk       (clk),
        .rst_n     (rst_n),
        .sym_valid (rx_sym_valid && s_reg.win_reg == LSW_RX),
        .sym       (rx_sym),
        .viol      (viol)
    );

    lsw_fifo u_fifo (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (fifo_wr),
        .wr_data (fifo_wd),
        .rd_en   (fifo_rd),
        .rd_data (fifo_rdata),
        .empty   (fifo_empty),
        .full    (fifo_full)
    );

    // =========================================
    // Frame length and handshake spacing
    always_comb begin
        case (rate_select)
            3'h3:    frame_len = 24'(FRAME_CYC_3);
            3'h4:    frame_len = 24'(FRAME_CYC_4);
            3'h5:    frame_len = 24'(FRAME_CYC_5);
            3'h6:    frame_len = 24'(FRAME_CYC_6);
            default: frame_len = 24'(FRAME_CYC_7);
        endcase
        case (handshake_bw_select)
            2'h0:    hs_gap = 16'(HS_GAP_0);
            2'h1:    hs_gap = 16'(HS_GAP_1);
            2'h2:    hs_gap = 16'(HS_GAP_2);
            default: hs_gap = 16'(HS_GAP_3);
        endcase
    end

    // =========================================
    // FIFO fill: handshake records take priority over data
    always_comb begin
        fifo_wr = 1'b0;
        fifo_wd = {2'h0, 1'b0, txd};
        if (s_reg.hs_pend_reg && !fifo_full) begin
            fifo_wr = 1'b1;
            fifo_wd = {HS_REC_TAG, dtr, rts};
        end else if (s_reg.ctrl_cnt_reg == 5'h0 && !fifo_full) begin
            fifo_wr = 1'b1;
        end
    end

    assign fifo_rd = (s_reg.win_reg == LSW_TX) && !fifo_empty;

    // =========================================
    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.tx_val_reg = 1'b0;
        s_next.rd_wait_reg = fifo_rd;

        // Control tick keeps the peer tracking even with static inputs
        if (s_reg.ctrl_cnt_reg == 5'(CTRL_BIT_CYC - 1)) begin
            s_next.ctrl_cnt_reg = 5'h0;
        end else begin
            s_next.ctrl_cnt_reg = s_reg.ctrl_cnt_reg + 5'h1;
        end

        // Handshake change capture, rate capped by gap counter
        if (s_reg.hs_gap_reg != 16'h0) begin
            s_next.hs_gap_reg = s_reg.hs_gap_reg - 16'h1;
        end
        if (s_reg.hs_pend_reg && fifo_wr) begin
            s_next.hs_pend_reg = 1'b0;
        end
        if ({dtr, rts} != s_reg.hs_last_reg && s_reg.hs_gap_reg == 16'h0) begin
            s_next.hs_last_reg = {dtr, rts};
            s_next.hs_pend_reg = 1'b1;
            s_next.hs_gap_reg  = hs_gap;
        end

        // Frame sequencer
        s_next.frame_cnt_reg = s_reg.frame_cnt_reg + 24'h1;
        case (s_reg.win_reg)
            LSW_IDLE: begin
                if (s_reg.frame_cnt_reg >= frame_len) begin
                    s_next.frame_cnt_reg = 24'h0;
                    s_next.win_reg = LSW_TX;
                end else if (rx_burst_start) begin
                    s_next.win_reg = LSW_RX;
                    s_next.got_burst_reg = 1'b1;
                end
            end
            LSW_TX: begin
                if (fifo_empty && !s_reg.rd_wait_reg) begin
                    s_next.win_reg = LSW_IDLE;
                    // Lock tracking once per frame, at the close of the transmit window; frame timing is never re-aligned to the peer
                    if (s_reg.got_burst_reg) begin
                        s_next.miss_reg = 2'h0;
                        s_next.locked_reg = 1'b1;
                    end else if (s_reg.miss_reg == 2'(LOCK_MISS_MAX)) begin
                        s_next.locked_reg = 1'b0;
                    end else begin
                        s_next.miss_reg = s_reg.miss_reg + 2'h1;
                    end
                    s_next.got_burst_reg = 1'b0;
                end
            end
            LSW_RX: begin
                if (rx_sym_last) begin
                    s_next.win_reg = LSW_IDLE;
                    s_next.rxd_reg = rx_data_bit;
                    s_next.cts_reg = rx_hs[0];
                    s_next.dsr_reg = rx_hs[1];
                end
            end
            default: s_next.win_reg = LSW_IDLE;
        endcase

        if (s_reg.rd_wait_reg) begin
            s_next.tx_sym_reg = fifo_rdata;
            s_next.tx_val_reg = 1'b1;
        end
        // DC-balanced code: light on half of the window
        s_next.tx_opt_reg = (s_reg.win_reg == LSW_TX) && s_reg.frame_cnt_reg[0];

        // Sticky code error; set only while locked, unlock wins and clears
        if (!s_next.locked_reg) begin
            s_next.err_reg = 1'b0;
        end
        if (viol && s_next.locked_reg) begin
            s_next.err_reg = 1'b1;
        end

        // Unlocked outputs are forced
        if (!s_next.locked_reg) begin
            s_next.rxd_reg = 1'b0;
            s_next.cts_reg = 1'b1;
            s_next.dsr_reg = 1'b1;
        end

        // Heartbeat period swaps with lock state; a running pulse is never stretched
        if (s_reg.locked_reg != s_next.locked_reg
            && s_reg.hb_cnt_reg >= 25'(HB_PULSE_CYC)) begin
            s_next.hb_cnt_reg = 25'h0;
        end else if (s_reg.hb_cnt_reg >= (s_reg.locked_reg ? 25'(HB_PERIOD_LOCK - 1)
                                                       : 25'(HB_PERIOD_UNLK - 1))) begin
            s_next.hb_cnt_reg = 25'h0;
        end else begin
            s_next.hb_cnt_reg = s_reg.hb_cnt_reg + 25'h1;
        end
        s_next.hb_reg = (s_next.hb_cnt_reg < 25'(HB_PULSE_CYC));
    end

    // =========================================
    // State register; reset length is the system's concern
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg             <= '0;
            s_reg.win_reg     <= LSW_IDLE;
            s_reg.err_reg     <= RST_ERR;
            s_reg.cts_reg     <= 1'b1;
            s_reg.dsr_reg     <= 1'b1;
            s_reg.hs_last_reg <= HS_RESET;
            s_reg.hb_reg      <= 1'b1; // Pulse starts at counter zero
        end else begin
            s_reg <= s_next;
        end
    end

    assign carrier_lock_n  = ~s_reg.locked_reg;
    assign code_error_flag = s_reg.err_reg;
    assign heartbeat_out   = s_reg.hb_reg;
    assign rxd             = s_reg.rxd_reg;
    assign cts             = s_reg.cts_reg;
    assign dsr             = s_reg.dsr_reg;
    assign tx_window       = (s_reg.win_reg == LSW_TX);
    assign rx_window       = (s_reg.win_reg == LSW_RX);
    assign tx_optical      = s_reg.tx_opt_reg;
    assign tx_sym          = s_reg.tx_sym_reg;
    assign tx_sym_valid    = s_reg.tx_val_reg;
endmodule
`default_nettype wire

// File: logic/lsw_pkg.sv
// Constants for link status and windowing logic.
// Assumes a 10 MHz system clock.
package lsw_pkg;
    // =========================================
    // Clock and timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned HB_PULSE_CYC    = 61440;
    localparam int unsigned HB_PERIOD_UNLK  = 1920000;
    localparam int unsigned HB_PERIOD_LOCK  = HB_PERIOD_UNLK * 8;
    localparam int unsigned CTRL_KBPS       = 200;
    localparam int unsigned CTRL_BIT_CYC    = CLK_HZ / (CTRL_KBPS * 1000);
    localparam int unsigned LOCK_MISS_MAX   = 3;
    // End-to-end delay in microseconds per rate code
    localparam int unsigned DLY_US_3        = 6500;
    localparam int unsigned DLY_US_4        = 3800;
    localparam int unsigned DLY_US_5        = 2800;
    localparam int unsigned DLY_US_6        = 2300;
    localparam int unsigned DLY_US_7        = 2000;
    localparam int unsigned FRAME_CYC_3     = DLY_US_3 * (CLK_HZ / 1_000_000) / 2;
    localparam int unsigned FRAME_CYC_4     = DLY_US_4 * (CLK_HZ / 1_000_000) / 2;
    localparam int unsigned FRAME_CYC_5     = DLY_US_5 * (CLK_HZ / 1_000_000) / 2;
    localparam int unsigned FRAME_CYC_6     = DLY_US_6 * (CLK_HZ / 1_000_000) / 2;
    localparam int unsigned FRAME_CYC_7     = DLY_US_7 * (CLK_HZ / 1_000_000) / 2;
    // Handshake sample spacing per bandwidth select
    localparam int unsigned HS_GAP_0        = 5000;
    localparam int unsigned HS_GAP_1        = 10000;
    localparam int unsigned HS_GAP_2        = 20000;
    localparam int unsigned HS_GAP_3        = 40000;
    // Reset values, record tag and FIFO sizes
    localparam logic        RST_LOCK_N      = 1'b1;
    localparam logic        RST_ERR         = 1'b0;
    localparam logic [1:0]  HS_RESET        = 2'h3;
    localparam logic [1:0]  HS_REC_TAG      = 2'h2;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam int unsigned FIFO_AW         = 4;
    localparam int unsigned REC_W           = 4;
endpackage

// File: logic/lsw_code_check.sv
// Checks 4-bit symbols against the DC-balanced 3B4B code.
// Assumes one symbol per strobe, synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module lsw_code_check
    import lsw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sym_valid,
    input  wire logic [3:0] sym,
    output logic            viol
);
    typedef struct packed {
        logic viol_reg;
    } lsw_cc_t;
    lsw_cc_t s_reg;
    lsw_cc_t s_next;

    // =========================================
    // Legal code words carry exactly two ones
    always_comb begin
        s_next          = s_reg;
        s_next.viol_reg = sym_valid && ($countones(sym) != 2);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign viol = s_reg.viol_reg;
endmodule
`default_nettype wire

// File: logic/lsw_fifo.sv
// Time-compression FIFO for data and handshake records.
// Assumes a single clock; read data come from a register.
`timescale 1ns/10ps
`default_nettype none
module lsw_fifo
    import lsw_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [REC_W-1:0] wr_data,
    input  wire logic             rd_en,
    output logic [REC_W-1:0]      rd_data,
    output logic                  empty,
    output logic                  full
);
    typedef struct packed {
        logic [FIFO_AW:0]   wp_reg;
        logic [FIFO_AW:0]   rp_reg;
        logic [REC_W-1:0]   rd_reg;
    } lsw_ff_t;
    lsw_ff_t s_reg;
    lsw_ff_t s_next;
    logic [REC_W-1:0] mem [FIFO_DEPTH];
    logic do_wr;
    logic do_rd;

    assign empty = (s_reg.wp_reg == s_reg.rp_reg);
    assign full  = (s_reg.wp_reg[FIFO_AW] != s_reg.rp_reg[FIFO_AW])
                && (s_reg.wp_reg[FIFO_AW-1:0] == s_reg.rp_reg[FIFO_AW-1:0]);
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;

    // =========================================
    // Pointer update
    always_comb begin
        s_next = s_reg;
        if (do_wr) begin
            s_next.wp_reg = s_reg.wp_reg + 1'b1;
        end
        if (do_rd) begin
            s_next.rp_reg = s_reg.rp_reg + 1'b1;
            s_next.rd_reg = mem[s_reg.rp_reg[FIFO_AW-1:0]];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[s_reg.wp_reg[FIFO_AW-1:0]] <= wr_data;
        end
    end

    assign rd_data = s_reg.rd_reg;
endmodule
`default_nettype wire

// File: test/lsw_top_assertions.sv
// Port checker for lsw_top: lock, error flag, heartbeat and windows.
// Assumes it is bound to lsw_top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module lsw_top_chk
    import lsw_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       rx_sym_valid,
    input wire logic [3:0] rx_sym,
    input wire logic       rx_sym_last,
    input wire logic       carrier_lock_n,
    input wire logic       code_error_flag,
    input wire logic       heartbeat_out,
    input wire logic       rxd,
    input wire logic       cts,
    input wire logic       dsr,
    input wire logic       tx_window,
    input wire logic       rx_window,
    input wire logic       tx_optical,
    input wire logic       tx_sym_valid
);
    logic [16:0] hb_cnt_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Helper
    // Counter instead of a long repetition
    always_ff @(posedge clk) begin
        hb_cnt_reg <= (!rst_n || !heartbeat_out) ? 17'h0 : hb_cnt_reg + 17'h1;
    end
    // ==========================================
    // Properties
    a_unlocked_forces: assert property (carrier_lock_n |-> !rxd && cts && dsr)
        else $error("rxd, cts or dsr not forced while unlocked");
    a_err_sets_flag: assert property (rx_sym_valid && rx_window && !carrier_lock_n
        && $countones(rx_sym) != 2 |-> ##2 (code_error_flag || carrier_lock_n))
        else $error("coding violation did not raise the error flag");
    a_err_sticky: assert property (code_error_flag |=> code_error_flag || carrier_lock_n)
        else $error("error flag dropped while locked");
    a_unlock_clears: assert property ($rose(carrier_lock_n) |-> ##[0:1] !code_error_flag)
        else $error("error flag not cleared on loss of lock");
    a_hb_pulse_len: assert property ($fell(heartbeat_out) |-> hb_cnt_reg == 17'(HB_PULSE_CYC))
        else $error("heartbeat pulse of wrong length");
    a_opt_half: assert property (tx_optical |=> !tx_optical)
        else $error("optical drive on two cycles in a row");
    a_tx_once: assert property ($fell(tx_window) |-> ##1 !tx_window [*8])
        else $error("transmit window reopened at once");
    a_sym_in_window: assert property (tx_sym_valid |-> tx_window || $past(tx_window))
        else $error("record sent outside the transmit window");
    a_rx_close: assert property (rx_sym_last && rx_window |=> !rx_window)
        else $error("receive window open after final bit");
endmodule
`default_nettype wire

// File: test/lsw_peer_model.sv
// Behavioural peer modem answering each local transmit window with a burst.
// Assumes one symbol every two cycles; idle lines toggle, never hold stale values.
`timescale 1ns/10ps
`default_nettype none
module lsw_peer_model #(
    parameter int GAP = 20
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       bad_sym,
    input  wire logic       tx_window,
    output logic            rx_burst_start = 1'b0,
    output logic            rx_sym_valid = 1'b0,
    output logic [3:0]      rx_sym = 4'h0,
    output logic            rx_sym_last = 1'b0,
    output logic            rx_data_bit = 1'b0,
    output logic [1:0]      rx_hs = 2'h0
);
    logic tx_prev = 1'b0;
    int   cnt = 0;
    always @(posedge clk) begin
        tx_prev        <= tx_window;
        rx_burst_start <= 1'b0;
        rx_sym_valid   <= 1'b0;
        rx_sym_last    <= 1'b0;
        rx_sym         <= ~rx_sym;
        rx_data_bit    <= ~rx_data_bit;
        rx_hs          <= ~rx_hs;
        if (!rst_n) begin
            cnt <= 0;
        end else if (cnt == 0) begin
            // Burst every frame, even with idle data
            if (enable && tx_prev && !tx_window) cnt <= 1;
        end else begin
            cnt <= cnt + 1;
            case (cnt)
                GAP: rx_burst_start <= 1'b1;
                GAP + 2, GAP + 4, GAP + 6: begin
                    rx_sym_valid <= 1'b1;
                    rx_sym       <= 4'h5;
                end
                GAP + 8: begin
                    rx_sym_valid <= 1'b1;
                    rx_sym       <= bad_sym ? 4'h7 : 4'h3;
                end
                GAP + 9: begin
                    rx_sym_last <= 1'b1;
                    rx_data_bit <= 1'b1;
                    rx_hs       <= 2'h0;
                    cnt         <= 0;
                end
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: test/lsw_top_bench.sv
// Self-checking bench for lsw_top facing a peer modem model.
// Assumes the fastest rate code so frames stay short.
`timescale 1ns/10ps
`default_nettype none
module lsw_top_bench
    import lsw_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] rate_select = 3'h7;
    logic [1:0] handshake_bw_select = 2'h0;
    logic       txd = 1'b0, rts = 1'b0, dtr = 1'b0, peer_en = 1'b1, bad_sym = 1'b0;
    logic       rx_sym_valid, rx_sym_last, rx_burst_start, rx_data_bit;
    logic [3:0] rx_sym, tx_sym;
    logic [1:0] rx_hs;
    logic       carrier_lock_n, code_error_flag, heartbeat_out, rxd, cts, dsr;
    logic       tx_window, rx_window, tx_optical, tx_sym_valid;
    int         n_errors = 0, checks = 0;

    lsw_top dut (
        .clk, .rst_n, .rate_select, .handshake_bw_select, .txd, .rts, .dtr,
        .rx_sym_valid, .rx_sym, .rx_sym_last, .rx_burst_start, .rx_data_bit, .rx_hs,
        .carrier_lock_n, .code_error_flag, .heartbeat_out, .rxd, .cts, .dsr,
        .tx_window, .rx_window, .tx_optical, .tx_sym, .tx_sym_valid
    );
    lsw_peer_model peer (
        .clk, .rst_n, .enable(peer_en), .bad_sym, .tx_window,
        .rx_burst_start, .rx_sym_valid, .rx_sym, .rx_sym_last, .rx_data_bit, .rx_hs
    );

    initial forever #50 clk = ~clk;

    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        repeat (3) @(posedge clk);
        rst_n <= 1'b1; // Short hold stands in for the long system reset
        @(posedge clk);
        @(negedge clk);
        check("lock_n", carrier_lock_n, 1'h1);
        check("err", code_error_flag, 1'h0);
        check("rxd_cts_dsr", {rxd, cts, dsr}, 3'h3);
        check("heartbeat", heartbeat_out, 1'h1);
    endtask
    task automatic t_heartbeat();
        int n;
        // Pulse already high on the negedge that reset release consumed
        n = 1;
        while (heartbeat_out === 1'b1 && n < 70000) begin
            n++;
            @(negedge clk);
        end
        check("pulse_len", n, HB_PULSE_CYC);
        check("hb_low", heartbeat_out, 1'h0);
    endtask
    task automatic t_lock_err();
        int i;
        for (i = 0; i < 60000 && carrier_lock_n !== 1'b0; i++) @(negedge clk);
        check("lock_n", carrier_lock_n, 1'h0);
        for (i = 0; i < 20000 && rx_sym_last !== 1'b1; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        check("rxd_cts_dsr", {rxd, cts, dsr}, 3'h4);
        @(posedge clk) bad_sym <= 1'b1;
        for (i = 0; i < 25000 && code_error_flag !== 1'b1; i++) @(negedge clk);
        check("err_set", code_error_flag, 1'h1);
        @(posedge clk) bad_sym <= 1'b0;
        repeat (12000) @(negedge clk);
        check("err_sticky", {code_error_flag, carrier_lock_n}, 2'h2);
    endtask
    task automatic t_handshake();
        int i;
        // Single slow change keeps handshake traffic far under the skew limit
        @(posedge clk) rts <= 1'b1;
        for (i = 0; i < 40000 && !(tx_sym_valid === 1'b1 && tx_sym[3] === 1'b1
             && tx_sym[0] === 1'b1); i++) @(negedge clk);
        check("hs_record", tx_sym, {HS_REC_TAG, 2'h1});
    endtask
    task automatic t_unlock();
        int i;
        @(posedge clk) peer_en <= 1'b0;
        for (i = 0; i < 70000 && carrier_lock_n !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        check("unlock_err", {carrier_lock_n, code_error_flag}, 2'h2);
        check("rxd_cts_dsr", {rxd, cts, dsr}, 3'h3);
    endtask

    // ==========================================
    // Sequence and watchdog
    initial begin
        t_reset();
        fork
            t_heartbeat();
            t_lock_err();
            t_handshake();
        join
        t_unlock();
        wrap_up();
    end
    initial begin
        repeat (130000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule
bind lsw_top lsw_top_chk u_chk (
    .clk, .rst_n, .rx_sym_valid, .rx_sym, .rx_sym_last, .carrier_lock_n,
    .code_error_flag, .heartbeat_out, .rxd, .cts, .dsr, .tx_window, .rx_window,
    .tx_optical, .tx_sym_valid
);
`default_nettype wire
